// *** rtl/mpp_positioner.sv ***
// module: per-phase pulse positioning modulator with current balance
`timescale 1ns/1ps
module mpp_positioner #(
	parameter int NUM_PH = mpp_pkg::NUM_PH,
	parameter int DATA_W = mpp_pkg::DATA_W,
	parameter int PER_W  = mpp_pkg::PER_W
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_n_i,
	input  wire logic [PER_W-1:0]         frequency_set_input_i,
	input  wire mpp_pkg::mpp_ctl_t        ctl_i,
	input  wire logic                     third_phase_enable_i,
	input  wire logic                     fourth_phase_enable_in_i,
	input  wire logic [NUM_PH*DATA_W-1:0] sensed_channel_current_i,
	output logic [NUM_PH-1:0]             pwm_o,
	output mpp_pkg::mpp_gate_t [2:0]      gate_o,
	output logic                          fourth_phase_pulse_out_o,
	output logic [DATA_W-1:0]             cycle_average_current_o,
	output logic                          window_start_o
);
	if (NUM_PH != 4 || DATA_W < 4 || PER_W < 4) begin : g_bad_param
		$error("mpp_positioner: unsupported parameters");
	end

	localparam int SW = DATA_W + 3;
	// pin syncs: third and fourth enable (three stages, accept on agreement)
	logic [2:0] en3_sync_reg, en3_sync_next, en4_sync_reg, en4_sync_next;
	logic       act3_reg, act3_next, act4_reg, act4_next;
	logic [PER_W-1:0] per_reg, per_next, cnt_reg, cnt_next;
	logic [NUM_PH-1:0] act;
	logic [NUM_PH-1:0] pwm_reg, pwm_next, rose_reg, rose_next, wstart;
	logic [NUM_PH-1:0][DATA_W-1:0] samp_reg, samp_next;
	logic signed [NUM_PH-1:0][SW-1:0] corr_reg, corr_next;
	logic [DATA_W-1:0] avg_reg, avg_next;
	logic [SW-1:0] sum;
	logic [2:0]    nact;

	assign act = {act4_reg, act3_reg, 2'b11};

	always_comb begin
		en3_sync_next = {en3_sync_reg[1:0], third_phase_enable_i};
		en4_sync_next = {en4_sync_reg[1:0], fourth_phase_enable_in_i};
		act3_next = (en3_sync_reg[2] == en3_sync_reg[1]) ? en3_sync_reg[1] : act3_reg;
		// tied to supply (high) disables the fourth phase
		act4_next = (en4_sync_reg[2] == en4_sync_reg[1]) ? ~en4_sync_reg[1] : act4_reg;
		// period captured at each period end; degenerate settings clamp
		per_next = (frequency_set_input_i < PER_W'(mpp_pkg::CNT_MIN))
			? PER_W'(mpp_pkg::CNT_MIN) : frequency_set_input_i;
		if (cnt_reg != per_reg - PER_W'(1))
			per_next = per_reg;
		cnt_next = (cnt_reg >= per_reg - PER_W'(1)) ? '0 : cnt_reg + PER_W'(1);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			en3_sync_reg <= '0;
			// idle at the disabled level so reset release cannot enable phase four briefly
			en4_sync_reg <= '1;
			act3_reg     <= 1'b0;
			act4_reg     <= 1'b0;
			per_reg      <= PER_W'(mpp_pkg::CNT_MIN);
			cnt_reg      <= mpp_pkg::PERIOD_RST;
		end else begin
			en3_sync_reg <= en3_sync_next;
			en4_sync_reg <= en4_sync_next;
			act3_reg     <= act3_next;
			act4_reg     <= act4_next;
			per_reg      <= per_next;
			cnt_reg      <= cnt_next;
		end
	end

	// active count and sum for the cycle average
	always_comb begin
		sum  = '0;
		nact = '0;
		for (int i = 0; i < NUM_PH; i++) begin
			if (act[i]) begin
				sum  = sum + SW'(sensed_channel_current_i[i*DATA_W +: DATA_W]);
				nact = nact + 3'h1;
			end
		end
	end

	always_comb begin
		avg_next = avg_reg;
		if (wstart[0]) begin
			case (nact)
				3'h2:    avg_next = DATA_W'(sum >> 1);
				3'h3:    avg_next = DATA_W'(sum / SW'(3));
				3'h4:    avg_next = DATA_W'(sum >> 2);
				default: avg_next = DATA_W'(sum);
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			avg_reg <= '0;
		else
			avg_reg <= avg_next;
	end

	genvar g;
	generate
		for (g = 0; g < NUM_PH; g++) begin : g_ph
			logic [PER_W-1:0]        off, pos;
			logic [PER_W+1:0]        offw;
			logic signed [SW:0]      berr, lvl;
			logic signed [SW:0]      ramp;
			logic [PER_W+DATA_W-1:0] rampw;
			logic                    above;
			// window offset spread by active count
			always_comb begin
				offw = ({2'b00, per_reg} * (PER_W+2)'(g)) / (PER_W+2)'(nact == 3'h0 ? 3'h1 : nact);
				off  = PER_W'(offw);
				pos  = (cnt_reg >= off) ? cnt_reg - off : cnt_reg + per_reg - off;
				wstart[g] = (pos == '0);
				berr = (SW+1)'($signed({1'b0, samp_reg[g]})) - (SW+1)'($signed({1'b0, avg_reg}));
				lvl  = (SW+1)'($signed({1'b0, ctl_i.error_amp_level}))
					- (SW+1)'($signed(corr_reg[g]));
				// ramp spans the window up to full scale, so full level keeps one low cycle
				rampw = {pos + PER_W'(1), {DATA_W{1'b0}}} / (PER_W+DATA_W)'(per_reg);
				ramp  = (SW+1)'($signed({1'b0, rampw[DATA_W:0]}));
				above = lvl > ramp;
			end

			always_comb begin
				samp_next[g] = wstart[g] ? sensed_channel_current_i[g*DATA_W +: DATA_W]
					: samp_reg[g];
				corr_next[g] = corr_reg[g];
				if (wstart[g] && act[g])
					corr_next[g] = corr_reg[g]
						+ SW'((berr - (SW+1)'($signed(corr_reg[g]))) >>> mpp_pkg::FILT_SHIFT);
				rose_next[g] = wstart[g] ? 1'b0 : rose_reg[g];
				pwm_next[g]  = pwm_reg[g];
				if (!act[g]) begin
					pwm_next[g] = 1'b0;
				end else if (ctl_i.transient_phase_alignment && !rose_next[g] && !pwm_reg[g]) begin
					pwm_next[g]  = 1'b1;
					rose_next[g] = 1'b1;
				end else if (!pwm_reg[g] && above && !rose_next[g]) begin
					pwm_next[g]  = 1'b1;
					rose_next[g] = 1'b1;
				end else if (pwm_reg[g] && !above && !ctl_i.transient_phase_alignment) begin
					pwm_next[g] = 1'b0;
				end else if (!pwm_reg[g]) begin
					pwm_next[g] = 1'b0;
				end
			end

			always_ff @(posedge clk_i) begin
				if (!rst_n_i) begin
					pwm_reg[g]  <= 1'b0;
					rose_reg[g] <= 1'b0;
					samp_reg[g] <= '0;
					corr_reg[g] <= '0;
				end else begin
					pwm_reg[g]  <= pwm_next[g];
					rose_reg[g] <= rose_next[g];
					samp_reg[g] <= samp_next[g];
					corr_reg[g] <= corr_next[g];
				end
			end

			property p_one_rise;
				@(posedge clk_i) disable iff (!rst_n_i)
				rose_reg[g] && !pwm_reg[g] && !wstart[g] |=> !pwm_reg[g];
			endproperty
			a_one_rise: assert property (p_one_rise) else $error("second rise inside one window");
		end
	endgenerate

	for (genvar k = 0; k < 3; k++) begin : g_gate
		assign gate_o[k].upper_gate_drive = pwm_reg[k];
		assign gate_o[k].lower_gate_drive = ~pwm_reg[k];
	end
	assign pwm_o                    = pwm_reg;
	assign fourth_phase_pulse_out_o = pwm_reg[3];
	assign cycle_average_current_o  = avg_reg;
	assign window_start_o           = wstart[0];

	property p_rise_once;
		@(posedge clk_i) disable iff (!rst_n_i)
		rose_reg[0] && !wstart[0] |=> !$rose(pwm_reg[0]);
	endproperty
	a_rise_once: assert property (p_rise_once) else $error("extra rise on phase one");

	property p_cnt_wrap;
		@(posedge clk_i) disable iff (!rst_n_i)
		cnt_reg >= per_reg - PER_W'(1) |=> cnt_reg == '0;
	endproperty
	a_cnt_wrap: assert property (p_cnt_wrap) else $error("interval counter missed wrap");

	property p_ph4_off;
		@(posedge clk_i) disable iff (!rst_n_i)
		!act4_reg |=> !fourth_phase_pulse_out_o;
	endproperty
	a_ph4_off: assert property (p_ph4_off) else $error("fourth phase pulsed while disabled");

	property p_gate_comp;
		@(posedge clk_i) disable iff (!rst_n_i)
		gate_o[0].upper_gate_drive != gate_o[0].lower_gate_drive;
	endproperty
	a_gate_comp: assert property (p_gate_comp) else $error("gate drives not complementary");

	property p_inactive_low;
		@(posedge clk_i) disable iff (!rst_n_i)
		!act3_reg ##1 !act3_reg |-> !pwm_reg[2];
	endproperty
	a_inactive_low: assert property (p_inactive_low) else $error("inactive phase pulsed");

	property p_samp;
		@(posedge clk_i) disable iff (!rst_n_i)
		wstart[1] |=> samp_reg[1] == $past(sensed_channel_current_i[DATA_W +: DATA_W]);
	endproperty
	a_samp: assert property (p_samp) else $error("sample not captured at window start");

	property p_rose_clear;
		@(posedge clk_i) disable iff (!rst_n_i)
		wstart[0] && !pwm_reg[0] && !ctl_i.transient_phase_alignment && !g_ph[0].above
			|=> !rose_reg[0];
	endproperty
	a_rose_clear: assert property (p_rose_clear) else $error("rise latch not cleared");

	property p_reset_low;
		@(posedge clk_i) !rst_n_i |=> pwm_reg == '0;
	endproperty
	a_reset_low: assert property (p_reset_low) else $error("outputs high after reset");

	c_rise: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(pwm_reg[0]));
	c_fall: cover property (@(posedge clk_i) disable iff (!rst_n_i) $fell(pwm_reg[1]));
	c_boost: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		ctl_i.transient_phase_alignment && pwm_reg[0] && pwm_reg[1]);
endmodule : mpp_positioner

// *** rtl/mpp_pkg.sv ***
// package: constants and carrier types for the multiphase pulse positioner
package mpp_pkg;
	localparam int NUM_PH     = 4;
	localparam int DATA_W     = 12;
	localparam int PER_W      = 16;
	localparam int FILT_SHIFT = 3;
	localparam logic [PER_W-1:0] PERIOD_RST = 16'h0000;
	localparam logic [1:0] CNT_MIN = 2'h2;

	typedef struct packed {
		logic upper_gate_drive;
		logic lower_gate_drive;
	} mpp_gate_t;

	typedef struct packed {
		logic [DATA_W-1:0] error_amp_level;
		logic              transient_phase_alignment;
	} mpp_ctl_t;
endpackage : mpp_pkg

// *** tb/mpp_drv_model.sv ***
// gate driver model for the three internal phases and the external fourth phase
`timescale 1ns/1ps
module mpp_drv_model (
	input  wire logic                     clk_i,
	input  wire mpp_pkg::mpp_gate_t [2:0] gate_i,
	input  wire logic                     ext_pwm_i,
	output logic [3:0]                    sw_high_o,
	output logic                          shoot_o
);
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 3; i++) begin
			// upper on connects switch node high, lower on pulls it low
			sw_high_o[i] <= gate_i[i].upper_gate_drive & ~gate_i[i].lower_gate_drive;
		end
		sw_high_o[3] <= ext_pwm_i;
		shoot_o <= |{gate_i[0].upper_gate_drive & gate_i[0].lower_gate_drive,
			gate_i[1].upper_gate_drive & gate_i[1].lower_gate_drive,
			gate_i[2].upper_gate_drive & gate_i[2].lower_gate_drive};
	end
endmodule // mpp_drv_model

// *** tb/multiphase_pwm_pulse_positioner_test.sv ***
// testbench for the multiphase pulse positioner
`timescale 1ns/1ps
module multiphase_pwm_pulse_positioner_test;
	logic                     clk_i = 0;
	logic                     rst_n_i = 0;
	logic [15:0]              per = 16'h0010;
	mpp_pkg::mpp_ctl_t        ctl = '0;
	logic                     en3 = 1;
	logic                     dis4 = 1;
	logic [47:0]              cur = {12'h190, 12'h12c, 12'h0c8, 12'h064};
	logic [3:0]               pwm;
	mpp_pkg::mpp_gate_t [2:0] gate;
	logic                     fourth_phase_pulse_out;
	logic [11:0]              avg;
	logic                     ws;
	logic [3:0]               swh;
	logic                     shoot;
	int                       mismatches = 0;
	int                       comparisons = 0;
	int                       cyc = 0;
	mpp_positioner dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .frequency_set_input_i(per),
		.ctl_i(ctl), .third_phase_enable_i(en3), .fourth_phase_enable_in_i(dis4),
		.sensed_channel_current_i(cur), .pwm_o(pwm), .gate_o(gate),
		.fourth_phase_pulse_out_o(fourth_phase_pulse_out), .cycle_average_current_o(avg), .window_start_o(ws));
	mpp_drv_model drv (.clk_i(clk_i), .gate_i(gate), .ext_pwm_i(fourth_phase_pulse_out), .sw_high_o(swh),
		.shoot_o(shoot));
	initial forever #5 clk_i = ~clk_i;
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 20000) begin
			mismatches++;
			results();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic next_window();
		int n;
		n = 0;
		tick(1);
		while (ws !== 1'b1 && n < 100) begin
			tick(1);
			n++;
		end
	endtask
	// watches one full window; counts phase-0 rises and gathers highs per phase
	task automatic watch(output int rises0, output logic [3:0] hi, output int len);
		logic [3:0] prev;
		next_window();
		rises0 = 0;
		hi = '0;
		len = 0;
		prev = pwm;
		do begin
			tick(1);
			len++;
			if (pwm[0] === 1'b1 && prev[0] === 1'b0) rises0++;
			hi |= pwm;
			chk({swh, shoot}, {prev, 1'b0});
			chk({gate[0].lower_gate_drive, gate[1].lower_gate_drive}, {~pwm[0], ~pwm[1]});
			chk(fourth_phase_pulse_out, pwm[3]);
			prev = pwm;
		end while (ws !== 1'b1 && len < 100);
	endtask
	task automatic t_reset();
		chk({pwm, fourth_phase_pulse_out}, 5'h00);
		chk(avg, 12'h000);
		chk({gate[0].lower_gate_drive, gate[1].lower_gate_drive, gate[2].lower_gate_drive}, 3'h7);
	endtask
	task automatic t_low_level();
		int r;
		int len;
		logic [3:0] hi;
		ctl.error_amp_level = 12'h000;
		watch(r, hi, len);
		watch(r, hi, len);
		chk(len, 16'h0010);
		chk(hi, 4'h0);
		chk(avg, 12'h0c8);
	endtask
	task automatic t_pulse();
		int r;
		int len;
		logic [3:0] hi;
		ctl.error_amp_level = 12'hfff;
		repeat (2) watch(r, hi, len);
		chk(hi[2:0], 3'h7);
		chk(hi[3], 1'b0);
		chk(r <= 1, 1'b1);
	endtask
	task automatic t_boost();
		int r;
		int len;
		logic [3:0] hi;
		ctl.error_amp_level = 12'h000;
		ctl.transient_phase_alignment = 1'b1;
		dis4 = 0;
		repeat (4) watch(r, hi, len);
		chk(hi, 4'hf);
		chk(r <= 1, 1'b1);
		chk(avg, 12'h0fa);
		ctl.transient_phase_alignment = 1'b0;
		repeat (3) watch(r, hi, len);
		chk(hi, 4'h0);
	endtask
	// mid level with unequal currents: low-current phases get longer pulses
	task automatic t_balance();
		int r;
		int len;
		int hc [4];
		int rs [4];
		logic [3:0] hi;
		logic [3:0] prev;
		ctl.error_amp_level = 12'h800;
		repeat (40) watch(r, hi, len);
		chk(hi, 4'hf);
		chk(avg, 12'h0fa);
		hc = '{default: 0};
		rs = '{default: 0};
		prev = pwm;
		for (int k = 1; k <= int'(per); k++) begin
			tick(1);
			for (int i = 0; i < 4; i++) begin
				hc[i] += int'(pwm[i]);
				if (pwm[i] === 1'b1 && prev[i] === 1'b0) rs[i] = k;
			end
			prev = pwm;
		end
		chk(hc[0] > hc[3], 1'b1);
		chk(hc[1] > hc[2], 1'b1);
		for (int i = 0; i < 4; i++) chk(rs[i], i * int'(per) / 4 + 1);
	endtask
	initial begin
		tick(12);
		t_reset();
		rst_n_i = 1;
		t_low_level();
		t_pulse();
		t_boost();
		t_balance();
		results();
	end
endmodule // multiphase_pwm_pulse_positioner_test
